// ===== rtl/lmr_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Header fault corrupts next packet header, then clears.
// - Payload fault corrupts next data check, then clears.
// - Drop bit discards next primary packet, then clears.
// - Override bit sends stored ack, then clears.
// - Suppress bit withholds next ack, then clears.
// - Eight-bit read/write override ack field.
// - Read-only ping time, 40 ns steps.
// - All registers clear to zero at reset.
// - Read bit issues PHY read request, then clears.
// - Write bit issues PHY write request, then clears.
// - Target address and write value fields read/write.
// - Returned address and value fields from PHY.
// - Bit 00 selects plain or packet protocol.
// - Transfer kind: PIO, multiword, ultra; 10 reserved.
// - Multiword speed 0-2 valid, others reserved.
// - Ultra speed 0-4 map to modes 0,1,1,2,3.
// - PIO speed 0-4 valid, others reserved.
// - Bit 00 is the register's most significant bit.
module lmr_regs
	import lmr_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [7:0]   busAddr,
	input  wire logic         busWrite,
	input  wire logic         busRead,
	input  wire logic [31:0]  busWdata,
	output logic [31:0]       busRdata,
	input  wire logic         txPrimaryDone,
	input  wire logic         txAckDone,
	output lmr_fault_s        faultCmd,
	input  wire logic         pingStart,
	input  wire logic         pingAnswer,
	output lmr_phy_req_s      phyReq,
	input  wire logic         phyReqTaken,
	input  wire logic         phyRetValid,
	input  wire logic [3:0]   phyRetAddr,
	input  wire logic [7:0]   phyRetData,
	output lmr_cfg_s          cfgOut
);

	logic [31:0] faultReg_r;
	logic [31:0] phyReg_r;
	logic [31:0] cfgReg_r;
	logic [8:0]  pingTime_r;
	logic [1:0]  pingDiv_r;
	logic        pingRun_r;
	logic        pingStartS1_r, pingStartS2_r, pingStartS3_r;
	logic        pingAnsS1_r, pingAnsS2_r, pingAnsS3_r;
	logic        pingStartEdge, pingAnsEdge;
	logic        wrFault, phy_write_request, wrCfg;

	// Write strobes; reserved slot and unmapped addresses take nothing
	assign wrFault = busWrite && (busAddr == LMR_ADDR_FAULT);
	assign phy_write_request   = busWrite && (busAddr == LMR_ADDR_PHY);
	assign wrCfg   = busWrite && (busAddr == LMR_ADDR_CFG);

	// Fault register: one-shot bits cleared by their event, set wins
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			faultReg_r <= LMR_RESET_VAL;
		else
		begin
			logic [31:0] v;
			v = faultReg_r;
			if (txPrimaryDone)
			begin
				v[LMR_FI_HDR]  = 1'b0;
				v[LMR_FI_PAY]  = 1'b0;
				v[LMR_FI_DROP] = 1'b0;
			end
			if (txAckDone)
			begin
				v[LMR_FI_OVR]  = 1'b0;
				v[LMR_FI_SUPP] = 1'b0;
			end
			if (wrFault)
				v = (v & ~LMR_MASK_FAULT) | (busWdata & LMR_MASK_FAULT) | (v & busWdata & LMR_MASK_FAULT);
			faultReg_r <= v & LMR_MASK_FAULT;
		end
	end

	// Ping timer synchronisers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pingStartS1_r <= 1'b0;
			pingStartS2_r <= 1'b0;
			pingAnsS1_r   <= 1'b0;
			pingAnsS2_r   <= 1'b0;
			pingStartS3_r <= 1'b0;
			pingAnsS3_r   <= 1'b0;
		end
		else
		begin
			pingStartS1_r <= pingStart;
			pingStartS2_r <= pingStartS1_r;
			pingAnsS1_r   <= pingAnswer;
			pingAnsS2_r   <= pingAnsS1_r;
			pingStartS3_r <= pingStartS2_r;
			pingAnsS3_r   <= pingAnsS2_r;
		end
	end

	// Edge detectors, so a line held high starts or stops the timer only once
	assign pingStartEdge = pingStartS2_r && !pingStartS3_r;
	assign pingAnsEdge   = pingAnsS2_r && !pingAnsS3_r;

	// Ping timer counts 40 ns steps from start to answer, saturating
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pingTime_r <= '0;
			pingDiv_r  <= '0;
			pingRun_r  <= 1'b0;
		end
		else if (pingStartEdge && !pingRun_r)
		begin
			pingTime_r <= '0;
			pingDiv_r  <= '0;
			pingRun_r  <= 1'b1;
		end
		else if (pingRun_r)
		begin
			if (pingAnsEdge)
				pingRun_r <= 1'b0;
			else if (pingDiv_r == 2'(LMR_PING_CYC - 1))
			begin
				pingDiv_r <= '0;
				if (pingTime_r != LMR_PING_MAX)
					pingTime_r <= pingTime_r + 9'h001;
			end
			else
				pingDiv_r <= pingDiv_r + 2'h1;
		end
	end

	// Phy_register_access register: request bits clear when taken, returns captured
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			phyReg_r <= LMR_RESET_VAL;
		else
		begin
			logic [31:0] v;
			v = phyReg_r;
			if (phyReqTaken)
			begin
				v[LMR_PH_RD] = 1'b0;
				v[LMR_PH_WR] = 1'b0;
			end
			if (phyRetValid)
			begin
				v[LMR_PH_RAD_LO +: 4] = phyRetAddr;
				v[LMR_PH_RDT_LO +: 8] = phyRetData;
			end
			if (phy_write_request)
				v = (v & ~LMR_MASK_PHY) | (busWdata & LMR_MASK_PHY);
			phyReg_r <= v;
		end
	end

	// Configuration register, loaded by firmware
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cfgReg_r <= LMR_RESET_VAL;
		else if (wrCfg)
			cfgReg_r <= busWdata & LMR_MASK_CFG;
	end

	// Read data; bit 00 is the word MSB
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			busRdata <= '0;
		else if (busRead)
		begin
			unique case (busAddr)
				LMR_ADDR_FAULT: busRdata <= faultReg_r | {23'h0, pingTime_r};
				LMR_ADDR_PHY:   busRdata <= phyReg_r;
				LMR_ADDR_CFG:   busRdata <= cfgReg_r;
				default:        busRdata <= '0;
			endcase
		end
	end

	// Outputs to the transmitter, PHY interface and storage sequencer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			faultCmd <= '0;
			phyReq   <= '0;
			cfgOut   <= '0;
		end
		else
		begin
			faultCmd.headerFault  <= faultReg_r[LMR_FI_HDR];
			faultCmd.payloadFault <= faultReg_r[LMR_FI_PAY];
			faultCmd.dropPacket   <= faultReg_r[LMR_FI_DROP];
			faultCmd.ackOverride  <= faultReg_r[LMR_FI_OVR];
			faultCmd.ackValue     <= faultReg_r[LMR_FI_ACK_LO +: 8];
			faultCmd.ackSuppress  <= faultReg_r[LMR_FI_SUPP];
			phyReq.valid <= (phyReg_r[LMR_PH_RD] | phyReg_r[LMR_PH_WR]) & ~phyReqTaken;
			phyReq.write <= phyReg_r[LMR_PH_WR];
			phyReq.addr  <= phyReg_r[LMR_PH_ADR_LO +: 4];
			phyReq.data  <= phyReg_r[LMR_PH_DAT_LO +: 8];
			cfgOut.packetProtocolSelect <= cfgReg_r[LMR_CF_PROT];
			cfgOut.transferKind <= lmr_kind_e'(cfgReg_r[LMR_CF_TM_LO +: 2]);
			cfgOut.blockTransferSpeed <= cfgReg_r[LMR_CF_DSP_LO +: 3];
			cfgOut.programmedIoSpeed  <= cfgReg_r[LMR_CF_PSP_LO +: 3];
			// Ultra table repeats mode 1 at setting 2
			case (cfgReg_r[LMR_CF_DSP_LO +: 3])
				3'h0:    cfgOut.udmaMode <= 3'h0;
				3'h1:    cfgOut.udmaMode <= 3'h1;
				3'h2:    cfgOut.udmaMode <= 3'h1;
				3'h3:    cfgOut.udmaMode <= 3'h2;
				default: cfgOut.udmaMode <= 3'h3;
			endcase
			case (cfgReg_r[LMR_CF_TM_LO +: 2])
				LMR_TK_PIO:  cfgOut.speedValid <= cfgReg_r[LMR_CF_PSP_LO +: 3] <= LMR_PIO_MAX;
				LMR_TK_MDMA: cfgOut.speedValid <= cfgReg_r[LMR_CF_DSP_LO +: 3] <= LMR_MDMA_MAX;
				LMR_TK_UDMA: cfgOut.speedValid <= cfgReg_r[LMR_CF_DSP_LO +: 3] <= LMR_UDMA_MAX;
				default:     cfgOut.speedValid <= 1'b0;
			endcase
		end
	end

endmodule

// ===== rtl/lmr_pkg.sv
package lmr_pkg;

	// Register byte addresses on the 32-bit processor bus
	localparam logic [7:0] LMR_ADDR_FAULT = 8'h1c;
	localparam logic [7:0] LMR_ADDR_RSVD  = 8'h20;
	localparam logic [7:0] LMR_ADDR_PHY   = 8'h24;
	localparam logic [7:0] LMR_ADDR_CFG   = 8'h28;

	// Reset value of every register
	localparam logic [31:0] LMR_RESET_VAL = 32'h0000_0000;

	// Field positions, given as LSB-numbered indices (bit 00 is index 31)
	localparam int LMR_FI_HDR    = 31;
	localparam int LMR_FI_PAY    = 30;
	localparam int LMR_FI_DROP   = 29;
	localparam int LMR_FI_OVR    = 28;
	localparam int LMR_FI_SUPP   = 27;
	localparam int LMR_FI_ACK_LO = 16;
	localparam int LMR_FI_PING_LO = 0;
	localparam int LMR_PH_RD     = 31;
	localparam int LMR_PH_WR     = 30;
	localparam int LMR_PH_ADR_LO = 24;
	localparam int LMR_PH_DAT_LO = 16;
	localparam int LMR_PH_RAD_LO = 8;
	localparam int LMR_PH_RDT_LO = 0;
	localparam int LMR_CF_PROT   = 31;
	localparam int LMR_CF_TM_LO  = 28;
	localparam int LMR_CF_DSP_LO = 20;
	localparam int LMR_CF_PSP_LO = 16;

	// Writable bit masks per register
	localparam logic [31:0] LMR_MASK_FAULT = 32'hf8ff_0000;
	localparam logic [31:0] LMR_MASK_PHY   = 32'hcfff_0000;
	localparam logic [31:0] LMR_MASK_CFG   = 32'hb077_0000;

	// Ping timer tick and its length in clock cycles
	localparam int LMR_CLK_NS     = 10;
	localparam int LMR_PING_NS    = 40;
	localparam int LMR_PING_CYC   = LMR_PING_NS / LMR_CLK_NS;
	localparam logic [8:0] LMR_PING_MAX = 9'h1ff;

	// Transfer kind encodings
	typedef enum logic [1:0] {
		LMR_TK_PIO  = 2'h0,
		LMR_TK_MDMA = 2'h1,
		LMR_TK_RSVD = 2'h2,
		LMR_TK_UDMA = 2'h3
	} lmr_kind_e;

	localparam logic [2:0] LMR_MDMA_MAX = 3'h2;
	localparam logic [2:0] LMR_UDMA_MAX = 3'h4;
	localparam logic [2:0] LMR_PIO_MAX  = 3'h4;

	// Decoded storage interface configuration
	typedef struct packed {
		logic      packetProtocolSelect;
		lmr_kind_e transferKind;
		logic [2:0] blockTransferSpeed;
		logic [2:0] programmedIoSpeed;
		logic [2:0] udmaMode;
		logic      speedValid;
	} lmr_cfg_s;

	// PHY register request
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [3:0] addr;
		logic [7:0] data;
	} lmr_phy_req_s;

	// Transmit fault commands
	typedef struct packed {
		logic       headerFault;
		logic       payloadFault;
		logic       dropPacket;
		logic       ackOverride;
		logic [7:0] ackValue;
		logic       ackSuppress;
	} lmr_fault_s;

endpackage

// ===== tb/lmr_regs_monitor.sv
`timescale 1ns/1ps
module lmr_regs_monitor
	import lmr_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         rst_n,
	input wire logic [7:0]   busAddr,
	input wire logic         busWrite,
	input wire logic         busRead,
	input wire logic [31:0]  busWdata,
	input wire logic [31:0]  busRdata,
	input wire logic         txPrimaryDone,
	input wire logic         txAckDone,
	input wire lmr_fault_s   faultCmd,
	input wire lmr_phy_req_s phyReq,
	input wire logic         phyReqTaken
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Write strobes for the fault and PHY registers
	wire wrF = busWrite && busAddr == LMR_ADDR_FAULT;
	wire wrP = busWrite && busAddr == LMR_ADDR_PHY;
	// Fault commands reach the transmitter two cycles after the write
	AST_FAULT_SET: assert property (wrF && busWdata[31:27] == 5'h1f |-> ##2 faultCmd.headerFault
		&& faultCmd.payloadFault && faultCmd.dropPacket && faultCmd.ackOverride
		&& faultCmd.ackSuppress && faultCmd.ackValue == $past(busWdata[23:16], 2)) else $error("fault set lost");
	AST_PKT_CLEAR: assert property (txPrimaryDone && !wrF |-> ##2 !faultCmd.headerFault
		&& !faultCmd.payloadFault && !faultCmd.dropPacket) else $error("packet fault not cleared");
	AST_ACK_CLEAR: assert property (txAckDone && !wrF |-> ##2 !faultCmd.ackOverride
		&& !faultCmd.ackSuppress) else $error("ack fault not cleared");
	// PHY request carries the stored address and data
	AST_PHY_REQ: assert property (wrP && busWdata[31:30] != 2'h0 && !phyReqTaken |-> ##2 phyReq.valid
		&& phyReq.write == $past(busWdata[30], 2) && phyReq.addr == $past(busWdata[27:24], 2)
		&& phyReq.data == $past(busWdata[23:16], 2)) else $error("phy request wrong");
	AST_PHY_DROP: assert property (phyReqTaken && !wrP |-> ##2 !phyReq.valid) else $error("phy request stuck");
	AST_RSVD_SLOT: assert property (busRead && busAddr == LMR_ADDR_RSVD |=> busRdata == 32'h0) else $error("slot");
	AST_RDATA_HOLD: assert property (!busRead |=> $stable(busRdata)) else $error("read data moved");
	AST_RESET_ZERO: assert property ($rose(rst_n) |-> busRdata == 32'h0 && faultCmd == '0
		&& !phyReq.valid) else $error("not zero after reset");
	cover property (wrF ##2 faultCmd.ackOverride);
	cover property (phyReqTaken && !phyReq.write);
	cover property (txPrimaryDone && faultCmd.dropPacket);
endmodule

bind lmr_regs lmr_regs_monitor lmr_regs_monitor_inst (.*);

// ===== tb/lmr_far_end.sv
`timescale 1ns/1ps
module lmr_far_end
	import lmr_pkg::*;
(
	input wire logic         clk_sys,
	input wire lmr_phy_req_s phyReq,
	input wire logic         slow,
	output logic             txPrimaryDone,
	output logic             txAckDone,
	output logic             phyReqTaken,
	output logic             phyRetValid,
	output logic [3:0]       phyRetAddr,
	output logic [7:0]       phyRetData
);
	logic [7:0]   regs [16];
	lmr_phy_req_s req;
	// PHY side: take each request, store writes, answer reads
	initial
	begin
		{txPrimaryDone, txAckDone, phyReqTaken, phyRetValid, phyRetAddr, phyRetData} = '0;
		foreach (regs[i]) regs[i] = 8'h0;
		forever
		begin
			@(posedge clk_sys iff phyReq.valid);
			repeat (slow ? 3 : 0) @(posedge clk_sys);
			#1 phyReqTaken = 1'b1;
			req = phyReq;
			if (req.write) regs[req.addr] = req.data;
			@(posedge clk_sys);
			#1 phyReqTaken = 1'b0;
			phyRetValid = !req.write;
			phyRetAddr = req.addr;
			phyRetData = regs[req.addr];
			@(posedge clk_sys);
			// Released lines show the inverse of the last value
			#1 phyRetValid = 1'b0;
			phyRetAddr = ~phyRetAddr;
			phyRetData = ~phyRetData;
		end
	end
	// One primary packet followed by one acknowledge
	task automatic sendPkt();
		@(posedge clk_sys);
		#1 txPrimaryDone = 1'b1;
		@(posedge clk_sys);
		#1 txPrimaryDone = 1'b0;
		txAckDone = 1'b1;
		@(posedge clk_sys);
		#1 txAckDone = 1'b0;
	endtask
endmodule

// ===== tb/lmr_regs_test.sv
`timescale 1ns/1ps
module lmr_regs_test
	import lmr_pkg::*;
;
	logic         clk_sys = 0, rst_n = 0, busWrite = 0, busRead = 0, pingStart = 0, pingAnswer = 0, slow = 0;
	logic [7:0]   busAddr = 8'h0;
	logic [31:0]  busWdata = 32'h0, busRdata, v, q;
	logic         txPrimaryDone, txAckDone, phyReqTaken, phyRetValid;
	logic [3:0]   phyRetAddr, a;
	logic [7:0]   phyRetData, d;
	logic [15:0]  ret = 16'h0;
	lmr_fault_s   faultCmd;
	lmr_phy_req_s phyReq;
	lmr_cfg_s     cfgOut;
	logic [31:0]  corner [5] = '{32'hffff_ffff, 32'ha000_0000, 32'h1030_0000, 32'h3040_0000, 32'h0005_0000};
	int           miscompares = 0, nTests = 0, cyc = 0;
	lmr_regs lmr_regs_inst (.*);
	lmr_far_end lmr_far_end_inst (.*);
	initial forever #5 clk_sys = ~clk_sys;
	// Cycle ceiling against hangs
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			testDone();
		end
	end
	// One bus cycle, read data taken after the answer edge
	task automatic bus(input logic [7:0] ad, input logic [31:0] wd, input logic w);
		busAddr = ad;
		busWdata = wd;
		busWrite = w;
		busRead = !w;
		@(posedge clk_sys);
		#1 busWrite = 0;
		busRead = 0;
		q = busRdata;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Read, retrying a bounded number of times until the value settles
	task automatic rdChk(input logic [7:0] ad, input logic [31:0] exp);
		for (int i = 0; i < 20; i++)
		begin
			bus(ad, 32'h0, 1'b0);
			if (q === exp) break;
		end
		chk(q, exp);
	endtask
	function automatic lmr_cfg_s expCfg(input logic [31:0] w);
		logic [2:0] s;
		s = w[22:20];
		expCfg = '{w[31], lmr_kind_e'(w[29:28]), s, w[18:16], 3'h0, 1'b0};
		expCfg.udmaMode = (s == 3'h0) ? 3'h0 : (s < 3'h3) ? 3'h1 : (s == 3'h3) ? 3'h2 : 3'h3;
		expCfg.speedValid = (w[29:28] == 2'h0) ? w[18:16] <= 3'h4 : (w[29:28] == 2'h1) ? s <= 3'h2
			: (w[29:28] == 2'h3) ? s <= 3'h4 : 1'b0;
	endfunction
	task automatic testDone();
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		void'($urandom(24));
		repeat (16) @(posedge clk_sys);
		#1 rst_n = 1;
		for (int i = 0; i < 4; i++) rdChk(8'h1c + 8'(4 * i), 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			v = (i < 5) ? corner[i] : $urandom;
			bus(LMR_ADDR_CFG, v, 1'b1);
			rdChk(LMR_ADDR_CFG, v & LMR_MASK_CFG);
			chk(32'(cfgOut), 32'(expCfg(v)));
			bus(i[0] ? LMR_ADDR_RSVD : 8'h30, $urandom, 1'b1);
			rdChk(i[0] ? LMR_ADDR_RSVD : 8'h30, 32'h0);
		end
		v = $urandom | 32'hf800_0000;
		bus(LMR_ADDR_FAULT, v, 1'b1);
		rdChk(LMR_ADDR_FAULT, v & LMR_MASK_FAULT);
		lmr_far_end_inst.sendPkt();
		rdChk(LMR_ADDR_FAULT, v & 32'h00ff_0000);
		for (int i = 0; i < 6; i++)
		begin
			slow = i[0];
			a = 4'($urandom);
			d = 8'($urandom);
			bus(LMR_ADDR_PHY, {4'h4, a, d, ret}, 1'b1);
			rdChk(LMR_ADDR_PHY, {4'h0, a, d, ret});
			bus(LMR_ADDR_PHY, {4'h8, a, 8'h0, ret}, 1'b1);
			ret = {4'h0, a, d};
			rdChk(LMR_ADDR_PHY, {4'h0, a, 8'h0, ret});
		end
		// Second reset in mid-run, with every register dirty
		rst_n = 0;
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1;
		for (int i = 0; i < 4; i++) rdChk(8'h1c + 8'(4 * i), 32'h0);
		chk(32'(cfgOut), 32'(expCfg(32'h0)));
		pingStart = 1;
		repeat (40) @(posedge clk_sys);
		#1 pingAnswer = 1;
		repeat (6) @(posedge clk_sys);
		#1 bus(LMR_ADDR_FAULT, 32'h0, 1'b0);
		chk(32'(q[8:0] >= 9'h9 && q[8:0] <= 9'hb), 32'h1);
		testDone();
	end
endmodule
